/* design/rcf_rx_client.sv */
`timescale 1ns/10ps
`include "rcf_params.svh"

module rcf_rx_client (
  input wire logic clk,
  input wire logic srst,
  input wire rcf_pkg::rcf_rate_t rate,
  input wire logic pre_fwd,
  input wire logic crc_fwd,
  input wire logic in_valid,
  input wire logic in_sop,
  input wire logic in_eop,
  input wire logic [63:0] in_data,
  input wire logic [2:0] in_empty,
  input wire logic [2:0] in_err,
  output logic in_ready,
  output logic rx_valid,
  output logic [511:0] rx_data,
  output logic rx_sop,
  output logic rx_eop,
  output logic [5:0] rx_empty,
  output logic [5:0] rx_error,
  output logic rx_status_valid,
  output logic [39:0] rx_status,
  output logic [63:0] rx_preamble,
  output logic [31:0] drop_count
);
  import rcf_pkg::*;

  // number of 64-bit chunks that make one client word
  function automatic logic [3:0] chunks_per_word(input rcf_rate_t r);
    case (r)
      RCF_RATE_100: chunks_per_word = `RCF_CPW_100;
      RCF_RATE_40: chunks_per_word = `RCF_CPW_40;
      RCF_RATE_10: chunks_per_word = `RCF_CPW_10;
      default: chunks_per_word = `RCF_CPW_10;
    endcase
  endfunction

  // drop a chunk into its slot, slot 0 at the top of the active word
  function automatic logic [511:0] place_chunk(input logic [511:0] base, input logic [63:0] c,
                                               input logic [3:0] n, input logic [2:0] s);
    logic [3:0] pos;
    place_chunk = base;
    pos = n - 4'h1 - {1'b0, s};
    for (int i = 0; i < `RCF_WORD_CHUNKS; i++) begin
      if (pos == i[3:0]) begin
        place_chunk[i*`RCF_CHUNK_W +: `RCF_CHUNK_W] = c;
      end
    end
  endfunction

  // unused bytes on the last word, counted up from byte 0
  function automatic logic [5:0] calc_empty(input logic [3:0] n, input logic [2:0] s,
                                            input logic [2:0] tail);
    logic [3:0] free;
    free = n - 4'h1 - {1'b0, s};
    calc_empty = {free[2:0], tail};
  endfunction

  // frame class from the header fields
  function automatic logic [39:0] make_status(input logic mc, input logic [15:0] t, input logic [15:0] op);
    make_status = '0;
    make_status[`RCF_ST_MCAST] = mc;
    make_status[`RCF_ST_CTRL] = (t == `RCF_ETYPE_CTRL);
    make_status[`RCF_ST_PAUSE] = (t == `RCF_ETYPE_CTRL) & (op == `RCF_PAUSE_OPCODE);
    make_status[`RCF_ST_VLAN] = (t == `RCF_ETYPE_VLAN) | (t == `RCF_ETYPE_QINQ);
  endfunction

  rcf_state_t state;
  logic [2:0] cidx;
  logic [511:0] acc;
  logic [15:0] nbytes;
  logic frame_first;
  logic [63:0] pre_reg;
  logic mcast;
  logic [15:0] ltype;
  logic [15:0] opcode;
  logic [2:0] gap;
  logic pend_valid;
  rcf_beat_t pend;

  rcf_beat_t cur_beat;
  rcf_beat_t fifo_in;
  rcf_beat_t fifo_out;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [`RCF_FIFO_AW:0] fifo_level;

  // beat classes; the sop beat of the input always carries the preamble
  wire [3:0] cpw = chunks_per_word(rate);
  wire pre_beat = in_valid & in_sop;
  wire data_beat = in_valid & ~in_sop & (state == RCF_FRAME);
  wire frame_end = data_beat & in_eop;
  wire pre_in_data = pre_fwd & (rate != RCF_RATE_40);
  wire chunk_go = data_beat | (pre_beat & pre_in_data);

  // word assembly: chunks fill the word from the top down, octet bits untouched
  wire [2:0] slot = pre_beat ? 3'h0 : cidx;
  wire last_slot = ({1'b0, slot} == (cpw - 4'h1));
  wire word_full = chunk_go & last_slot;
  wire word_end = word_full | frame_end;
  wire [511:0] acc_base = (slot == 3'h0) ? '0 : acc;
  wire [511:0] word_now = place_chunk(acc_base, in_data, cpw, slot);

  // header fields, taken straight from the bus when the frame ends on that chunk
  wire first_chunk = (nbytes == 16'h0000);
  wire second_chunk = (nbytes == `RCF_CHUNK_BYTES);
  wire mcast_now = first_chunk ? in_data[`RCF_MCAST_BIT] : mcast;
  wire [15:0] type_now = second_chunk ? in_data[31:16] : ltype;
  wire [15:0] opc_now = second_chunk ? in_data[15:0] : opcode;
  wire [15:0] nbytes_fin = nbytes + `RCF_CHUNK_BYTES - {13'h0000, in_empty};

  // length field check only for plain length frames without a size or malformed error
  wire len_short = (type_now <= `RCF_MAX_LEN_FIELD) & (nbytes_fin < (type_now + `RCF_HDR_CRC_BYTES));
  wire len_err = len_short & ~in_err[`RCF_ER_SIZE] & ~in_err[`RCF_ER_MALFORMED];
  wire [5:0] error_now = {1'b0, len_err, 1'b0, in_err};

  // the 40GE/50GE adapter cannot pass tiny frames; they fit in one word, so nothing leaked yet
  wire [15:0] min_len = crc_fwd ? `RCF_MIN_LEN_CRC : `RCF_MIN_LEN_NOCRC;
  wire short_drop = frame_end & (rate == RCF_RATE_40) & (nbytes_fin < min_len);

  // a one-word frame at 100GE waits until the next start is known to be far enough away
  wire hold_single = frame_end & frame_first & (rate == RCF_RATE_100);
  wire stale_drop = pre_beat & pend_valid & (gap < `RCF_START_SPACING);
  wire release_pend = pend_valid & (gap >= `RCF_START_SPACING);
  wire push_now = word_end & ~short_drop & ~hold_single;

  // beat as built this cycle; error and status only ride the last word
  always_comb begin
    cur_beat.sop = pre_beat | frame_first;
    cur_beat.eop = frame_end;
    cur_beat.empty = frame_end ? calc_empty(cpw, slot, in_empty) : 6'h00;
    cur_beat.error = frame_end ? error_now : 6'h00;
    cur_beat.status = frame_end ? make_status(mcast_now, type_now, opc_now) : 40'h0000000000;
    cur_beat.preamble = (pre_fwd & (rate == RCF_RATE_40)) ? pre_reg : 64'h0000000000000000;
    cur_beat.data = word_now;
  end

  // a held frame never collides with a live push: live words need more chunks than the spacing
  assign fifo_in = release_pend ? pend : cur_beat;

  // frame tracking
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= RCF_IDLE;
    end else if (pre_beat) begin
      state <= RCF_FRAME;
    end else if (frame_end) begin
      state <= RCF_IDLE;
    end
  end

  // slot pointer and word accumulator
  always_ff @(posedge clk) begin
    if (srst) begin
      cidx <= 3'h0;
    end else if (chunk_go) begin
      cidx <= (last_slot | frame_end) ? 3'h0 : slot + 3'h1;
    end else if (pre_beat) begin
      cidx <= 3'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (chunk_go) begin
      acc <= word_now;
    end
  end

  // octet count and first-word marker
  always_ff @(posedge clk) begin
    if (srst) begin
      nbytes <= 16'h0000;
      frame_first <= 1'b0;
    end else if (pre_beat) begin
      nbytes <= 16'h0000;
      frame_first <= ~word_full;
    end else if (data_beat) begin
      nbytes <= nbytes + `RCF_CHUNK_BYTES;
      if (word_end) begin
        frame_first <= 1'b0;
      end
    end
  end

  // preamble and header capture
  always_ff @(posedge clk) begin
    if (srst) begin
      pre_reg <= 64'h0000000000000000;
      mcast <= 1'b0;
      ltype <= 16'h0000;
      opcode <= 16'h0000;
    end else if (pre_beat) begin
      pre_reg <= in_data;
      mcast <= 1'b0;
      ltype <= 16'h0000;
      opcode <= 16'h0000;
    end else if (data_beat) begin
      mcast <= mcast_now;
      ltype <= type_now;
      opcode <= opc_now;
    end
  end

  // clocks since the latest frame start, saturating at the spacing
  always_ff @(posedge clk) begin
    if (srst) begin
      gap <= `RCF_START_SPACING;
    end else if (pre_beat) begin
      gap <= 3'h1;
    end else if (gap < `RCF_START_SPACING) begin
      gap <= gap + 3'h1;
    end
  end

  // single-word 100GE frame held back; a new hold overrides a release in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      pend_valid <= 1'b0;
    end else if (hold_single) begin
      pend_valid <= 1'b1;
    end else if (release_pend | stale_drop) begin
      pend_valid <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (hold_single) begin
      pend <= cur_beat;
    end
  end

  // both drop causes come from different beat kinds, so one increment per cycle is enough
  always_ff @(posedge clk) begin
    if (srst) begin
      drop_count <= 32'h00000000;
    end else if (short_drop | stale_drop) begin
      drop_count <= drop_count + 32'h00000001;
    end
  end

  // output buffer; the client side always drains
  rcf_fifo #(
    .W($bits(rcf_beat_t)),
    .D(`RCF_FIFO_DEPTH),
    .AW(`RCF_FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .srst(srst),
    .in_valid(release_pend | push_now),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(1'b1),
    .out_data(fifo_out),
    .level(fifo_level)
  );

  // registered ready keeps headroom for beats already in flight upstream
  always_ff @(posedge clk) begin
    if (srst) begin
      in_ready <= 1'b0;
    end else begin
      in_ready <= fifo_in_ready & (fifo_level < `RCF_READY_LEVEL);
    end
  end

  // client outputs straight from flip-flops
  always_ff @(posedge clk) begin
    if (srst) begin
      rx_valid <= 1'b0;
      rx_sop <= 1'b0;
      rx_eop <= 1'b0;
      rx_status_valid <= 1'b0;
    end else begin
      rx_valid <= fifo_out_valid;
      rx_sop <= fifo_out_valid & fifo_out.sop;
      rx_eop <= fifo_out_valid & fifo_out.eop;
      rx_status_valid <= fifo_out_valid & fifo_out.eop;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rx_data <= '0;
      rx_empty <= 6'h00;
      rx_error <= 6'h00;
      rx_status <= 40'h0000000000;
      rx_preamble <= 64'h0000000000000000;
    end else if (fifo_out_valid) begin
      rx_data <= fifo_out.data;
      rx_empty <= fifo_out.empty;
      rx_error <= fifo_out.error;
      rx_status <= fifo_out.status;
      rx_preamble <= fifo_out.preamble;
    end
  end

endmodule // rcf_rx_client

/* design/rcf_params.svh */
`ifndef RCF_PARAMS_SVH
`define RCF_PARAMS_SVH

// widths of the incoming chunk and the outgoing client word
`define RCF_CHUNK_W 64
`define RCF_WORD_W 512
`define RCF_WORD_CHUNKS 8

// chunks per client word at each rate
`define RCF_CPW_100 4'h8
`define RCF_CPW_40 4'h2
`define RCF_CPW_10 4'h1

// output buffer shape and the margin kept free behind the registered ready
`define RCF_FIFO_DEPTH 32
`define RCF_FIFO_AW 5
`define RCF_READY_LEVEL 6'h1C

// shortest frames kept at 40GE/50GE, in octets
`define RCF_MIN_LEN_CRC 16'h0009
`define RCF_MIN_LEN_NOCRC 16'h000D

// least spacing of two frame starts at 100GE, in 64-bit blocks (one per clock)
`define RCF_START_SPACING 3'h5

// header decode constants
`define RCF_ETYPE_CTRL 16'h8808
`define RCF_ETYPE_VLAN 16'h8100
`define RCF_ETYPE_QINQ 16'h88A8
`define RCF_PAUSE_OPCODE 16'h0001
`define RCF_MAX_LEN_FIELD 16'h05DC
`define RCF_HDR_CRC_BYTES 16'h0012
`define RCF_CHUNK_BYTES 16'h0008
`define RCF_MCAST_BIT 56

// status word bit positions
`define RCF_ST_MCAST 37
`define RCF_ST_PAUSE 35
`define RCF_ST_CTRL 34
`define RCF_ST_VLAN 33

// error vector bit positions
`define RCF_ER_MALFORMED 0
`define RCF_ER_CRC 1
`define RCF_ER_SIZE 2
`define RCF_ER_LEN 4

`endif

/* design/rcf_pkg.sv */
package rcf_pkg;

  // line rate of the client port
  typedef enum logic [1:0] {
    RCF_RATE_100 = 2'h0,
    RCF_RATE_40 = 2'h1,
    RCF_RATE_10 = 2'h2
  } rcf_rate_t;

  // frame tracking states, one-hot
  typedef enum logic [1:0] {
    RCF_IDLE = 2'h1,
    RCF_FRAME = 2'h2
  } rcf_state_t;

  // one client beat as it travels through the buffer
  typedef struct packed {
    logic sop;
    logic eop;
    logic [5:0] empty;
    logic [5:0] error;
    logic [39:0] status;
    logic [63:0] preamble;
    logic [511:0] data;
  } rcf_beat_t;

endpackage

/* design/rcf_fifo.sv */
`timescale 1ns/10ps
`include "rcf_params.svh"

module rcf_fifo #(
  parameter int W = 8,
  parameter int D = `RCF_FIFO_DEPTH,
  parameter int AW = `RCF_FIFO_AW
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [AW:0] level
);

  logic [W-1:0] mem [0:D-1];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;

  // entries still in the array; the output register holds one more
  wire push = in_valid & in_ready;
  wire load = (cnt != '0) & (~out_valid | out_ready);
  assign in_ready = (cnt != D[AW:0]);

  // array write, no reset needed on the storage itself
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  // read data comes out of a register, loaded ahead of the drain
  always_ff @(posedge clk) begin
    if (load) begin
      out_data <= mem[rp];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wp <= wp + 1'b1;
      end
      if (load) begin
        rp <= rp + 1'b1;
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      cnt <= cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
    end
  end

  assign level = cnt;

endmodule // rcf_fifo

/* verif/rcf_client_sink.sv */
`timescale 1ns/10ps
module rcf_client_sink (
  input wire logic clk,
  input wire logic rx_valid,
  input wire logic [511:0] rx_data,
  input wire logic rx_sop,
  input wire logic rx_eop,
  input wire logic [5:0] rx_empty,
  input wire logic [5:0] rx_error,
  input wire logic [39:0] rx_status,
  input wire logic [63:0] rx_preamble
);
  import rcf_pkg::*;
  rcf_beat_t beats[$];
  // every beat is taken at once, this client has no way to stall the port
  always @(posedge clk) begin
    if (rx_valid === 1'b1) begin
      beats.push_back('{rx_sop, rx_eop, rx_empty, rx_error, rx_status, rx_preamble, rx_data});
    end
  end
endmodule // rcf_client_sink

/* verif/rcf_rx_client_assertions.sv */
`timescale 1ns/10ps
module rcf_rx_client_checker (
  input wire logic clk,
  input wire logic srst,
  input wire rcf_pkg::rcf_rate_t rate,
  input wire logic pre_fwd,
  input wire logic rx_valid,
  input wire logic rx_sop,
  input wire logic rx_eop,
  input wire logic [5:0] rx_empty,
  input wire logic [5:0] rx_error,
  input wire logic rx_status_valid,
  input wire logic [39:0] rx_status,
  input wire logic [31:0] drop_count
);
  import rcf_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // framing side fields are zero away from the last word
  stat_valid_a: assert property (rx_status_valid == (rx_valid && rx_eop)) else $error("status valid mismatch");
  err_idle_a: assert property (rx_valid && !rx_eop |-> rx_error == 6'h00) else $error("error off eop");
  err_rsvd_a: assert property (rx_valid |-> !rx_error[3] && !rx_error[5]) else $error("reserved error bit");
  status_idle_a: assert property (rx_valid && !rx_eop |-> rx_status == 40'h0) else $error("status off eop");
  empty_idle_a: assert property (rx_valid && !rx_eop |-> rx_empty == 6'h00) else $error("empty off eop");
  // at least one byte stays valid in the active width
  empty_ten_a: assert property (rx_valid && rx_eop && rate == RCF_RATE_10 |-> rx_empty < 6'h08)
    else $error("empty too large at 10G");
  empty_forty_a: assert property (rx_valid && rx_eop && rate == RCF_RATE_40 |-> rx_empty < 6'h10)
    else $error("empty too large at 40G");
  pre_beat_a: assert property (rx_valid && rx_sop && pre_fwd && rate == RCF_RATE_10 |-> !rx_eop)
    else $error("preamble word not alone");
  drop_step_a: assert property (drop_count == $past(drop_count) || drop_count == $past(drop_count) + 32'h1)
    else $error("drop count jumped");
  cover property (rx_status_valid);
  cover property (drop_count != $past(drop_count));
  cover property (rx_valid && rx_sop && rx_eop);
endmodule // rcf_rx_client_checker

bind rcf_rx_client rcf_rx_client_checker chk_u (.clk(clk), .srst(srst), .rate(rate), .pre_fwd(pre_fwd),
  .rx_valid(rx_valid), .rx_sop(rx_sop), .rx_eop(rx_eop), .rx_empty(rx_empty), .rx_error(rx_error),
  .rx_status_valid(rx_status_valid), .rx_status(rx_status), .drop_count(drop_count));

/* verif/testbench.sv */
`timescale 1ns/10ps
module testbench;
  import rcf_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  rcf_rate_t rate = RCF_RATE_100;
  logic pre_fwd = 1'b0;
  logic crc_fwd = 1'b0;
  logic in_valid = 1'b0;
  logic in_sop = 1'b0;
  logic in_eop = 1'b0;
  logic [63:0] in_data = 64'h0;
  logic [2:0] in_empty = 3'h0;
  logic [2:0] in_err = 3'h0;
  logic in_ready, rx_valid, rx_sop, rx_eop, rx_status_valid;
  logic [511:0] rx_data;
  logic [5:0] rx_empty, rx_error;
  logic [39:0] rx_status;
  logic [63:0] rx_preamble;
  logic [31:0] drop_count;
  logic [7:0] fb [0:63];
  logic [63:0] pre = 64'h5555_5555_5555_55D5;
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;

  rcf_rx_client dut_u (.clk(clk), .srst(srst), .rate(rate), .pre_fwd(pre_fwd), .crc_fwd(crc_fwd),
    .in_valid(in_valid), .in_sop(in_sop), .in_eop(in_eop), .in_data(in_data), .in_empty(in_empty),
    .in_err(in_err), .in_ready(in_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_sop(rx_sop),
    .rx_eop(rx_eop), .rx_empty(rx_empty), .rx_error(rx_error), .rx_status_valid(rx_status_valid),
    .rx_status(rx_status), .rx_preamble(rx_preamble), .drop_count(drop_count));
  rcf_client_sink sink_u (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_sop(rx_sop),
    .rx_eop(rx_eop), .rx_empty(rx_empty), .rx_error(rx_error), .rx_status(rx_status),
    .rx_preamble(rx_preamble));
  initial begin
    forever #50 clk = ~clk;
  end

  task automatic check(string name, logic [511:0] seen, logic [511:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // a hung handshake ends the run as a failure
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      report_and_stop();
    end
  end

  task automatic beat(logic s, logic e, logic [63:0] d, logic [2:0] em, logic [2:0] er);
    in_valid = 1'b1;
    in_sop = s;
    in_eop = e;
    in_data = d;
    in_empty = em;
    in_err = er;
    @(posedge clk);
    #1;
  endtask

  // preamble beat, then chunks from fb, unused tail octets zero; ends with one idle cycle
  task automatic send(int n, logic [2:0] er);
    int c;
    int k;
    logic last;
    logic [63:0] d;
    beat(1'b1, 1'b0, pre, 3'h0, 3'h0);
    for (c = 0; c * 8 < n; c++) begin
      for (k = 0; k < 8; k++) d[63 - 8 * k -: 8] = (c * 8 + k < n) ? fb[c * 8 + k] : 8'h00;
      last = ((c + 1) * 8 >= n);
      beat(1'b0, last, d, last ? 3'((c + 1) * 8 - n) : 3'h0, last ? er : 3'h0);
    end
    in_valid = 1'b0;
    in_sop = 1'b0;
    in_eop = 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic fill(logic [7:0] b0, logic [15:0] ty);
    for (int k = 0; k < 64; k++) fb[k] = 8'(k + 32);
    fb[0] = b0;
    fb[12] = ty[15:8];
    fb[13] = ty[7:0];
    fb[14] = 8'h00;
    fb[15] = 8'h01;
  endtask

  // bytes fb[first..] placed from the top of a word of wb bytes, the rest zero
  function automatic logic [511:0] word(int first, int nb, int wb);
    logic [511:0] w;
    w = 512'h0;
    for (int k = 0; k < nb; k++) w[8 * wb - 1 - 8 * k -: 8] = fb[first + k];
    return w;
  endfunction

  task automatic collect(int n);
    for (int i = 0; i < 60 && (i < 12 || sink_u.beats.size() < n); i++) @(posedge clk);
    #1;
    check("beat count", sink_u.beats.size(), n);
  endtask

  task automatic t_hdr100();
    fill(8'h01, 16'h8808);
    send(64, 3'h0);
    collect(1);
    check("data100", sink_u.beats[0].data, word(0, 64, 64));
    check("frame100", {sink_u.beats[0].sop, sink_u.beats[0].eop, sink_u.beats[0].empty}, 8'hC0);
    check("status100", sink_u.beats[0].status, 40'h2C_0000_0000);
    check("error100", sink_u.beats[0].error, 6'h00);
    sink_u.beats.delete();
  endtask

  task automatic t_pre100();
    pre_fwd = 1'b1;
    fill(8'h02, 16'h0800);
    send(20, 3'h0);
    collect(1);
    check("pre100", sink_u.beats[0].data, word(0, 20, 56) | {pre, 448'h0});
    check("empty100", sink_u.beats[0].empty, 6'h24);
    sink_u.beats.delete();
  endtask

  task automatic t_hdr40();
    rate = RCF_RATE_40;
    crc_fwd = 1'b1;
    fill(8'h02, 16'h8100);
    send(20, 3'h2);
    collect(2);
    check("data40a", sink_u.beats[0].data, word(0, 16, 16));
    check("pre40", sink_u.beats[0].preamble, pre);
    check("data40b", sink_u.beats[1].data, word(16, 4, 16));
    check("empty40", sink_u.beats[1].empty, 6'h0C);
    check("error40", sink_u.beats[1].error, 6'h02);
    check("status40", sink_u.beats[1].status, 40'h02_0000_0000);
    sink_u.beats.delete();
  endtask

  task automatic t_hdr10();
    rate = RCF_RATE_10;
    fill(8'h02, 16'h0030);
    send(14, 3'h0);
    collect(3);
    check("pre10", sink_u.beats[0].data, {448'h0, pre});
    check("pre10 frame", {sink_u.beats[0].sop, sink_u.beats[0].eop}, 2'b10);
    check("data10a", sink_u.beats[1].data, word(0, 8, 8));
    check("data10b", sink_u.beats[2].data, word(8, 6, 8));
    check("empty10", sink_u.beats[2].empty, 6'h02);
    check("error10", sink_u.beats[2].error, 6'h10);
    sink_u.beats.delete();
  endtask

  // minimum-length boundaries on both sides of each limit
  task automatic t_drop40();
    logic [31:0] d0;
    int n [4] = '{8, 9, 12, 13};
    logic [3:0] cf = 4'b1100;
    logic [3:0] gone = 4'b1010;
    rate = RCF_RATE_40;
    pre_fwd = 1'b0;
    for (int i = 0; i < 4; i++) begin
      crc_fwd = cf[3 - i];
      fill(8'h02, 16'h0800);
      d0 = drop_count;
      send(n[i], 3'h0);
      collect(gone[3 - i] ? 0 : 1);
      check("drop40", drop_count, d0 + gone[3 - i]);
      sink_u.beats.delete();
    end
  endtask

  task automatic t_close100();
    logic [31:0] d0;
    rate = RCF_RATE_100;
    d0 = drop_count;
    fill(8'h02, 16'h0800);
    send(16, 3'h0);
    fill(8'h03, 16'h0800);
    send(16, 3'h0);
    collect(1);
    check("later kept", sink_u.beats[0].data, word(0, 16, 64));
    check("drop100", drop_count, d0 + 32'h1);
    sink_u.beats.delete();
  endtask

  // frames streamed through the buffer keep their order, the source is never stalled, the port drains
  task automatic t_burst10();
    logic ready_low;
    rate = RCF_RATE_10;
    pre_fwd = 1'b0;
    ready_low = 1'b0;
    for (int i = 0; i < 4; i++) begin
      fill(8'(16 + i), 16'h0800);
      send(16, 3'h0);
      ready_low = ready_low | ~in_ready;
    end
    collect(8);
    check("ready held", ready_low, 1'b0);
    for (int i = 0; i < 4; i++) begin
      check("burst order", {sink_u.beats[2 * i].sop, sink_u.beats[2 * i].data[63:56]}, {1'b1, 8'(16 + i)});
    end
    check("burst drained", rx_valid, 1'b0);
    sink_u.beats.delete();
  endtask

  initial begin
    repeat (20) @(posedge clk);
    #1;
    srst = 1'b0;
    for (int i = 0; i < 10 && in_ready !== 1'b1; i++) @(posedge clk);
    #1;
    check("in_ready", in_ready, 1'b1);
    t_hdr100();
    t_pre100();
    t_hdr40();
    t_hdr10();
    t_drop40();
    t_close100();
    t_burst10();
    report_and_stop();
  end
endmodule // testbench
